// ==== rtl/dpwsa_cfg.svh ====
// Overview of operation
// R1: Device writes only while selects and write overlap.
// R2: Address changes only with write or selects inactive.
// R3: Late select after write low keeps outputs off.
// R4: Write pulse covers turnoff plus set-up when enabled.
// R5: Memory and flag selects stay valid throughout access.
// R6: Flag read drives all sixteen lines alike.
// R7: Free flag reads ones; request writes zero.
// R8: Simultaneous flag requests grant exactly one port.
// R9: Master holds only the later of matching ports.
// R10: Hold asserts on match, releases on mismatch.
// R11: External arbiter asserts hold before write start.
// R12: Losing host keeps write for hold time after release.
// R13: Data valid after hold release within derived delay.
// R14: Written data reaches opposite port within delays.
// R15: Device discards writes while driving hold low.
// R16: Master never drives both holds low together.
// R17: Mode select makes hold pins outputs or inputs.
// R18: Owner reads flag zero; writing one releases it.
`ifndef DPWSA_CFG_SVH
`define DPWSA_CFG_SVH

// ----------------------------------------------------------------------------
// Widths, bit positions and timing
// ----------------------------------------------------------------------------
`define DPWSA_ADDR_W      12
`define DPWSA_DATA_W      16
`define DPWSA_FLAG_BIT    0
`define DPWSA_CLK_NS      40
`define DPWSA_WP_NS       50
`define DPWSA_WH_NS       25
`define DPWSA_RD_NS       70
`define DPWSA_BDD_NS      45
`define DPWSA_CYC(ns)     ((((ns) + `DPWSA_CLK_NS - 1) / `DPWSA_CLK_NS) < 1 ? 1 : \
                           (((ns) + `DPWSA_CLK_NS - 1) / `DPWSA_CLK_NS))
`define DPWSA_TMR_W       4

`endif

// ==== rtl/dpwsa_host.sv ====
`include "dpwsa_cfg.svh"

module dpwsa_host #(
    parameter int AW      = `DPWSA_ADDR_W,
    parameter int DW      = `DPWSA_DATA_W,
    parameter int WP_CYC  = `DPWSA_CYC(`DPWSA_WP_NS),
    parameter int WH_CYC  = `DPWSA_CYC(`DPWSA_WH_NS),
    parameter int RD_CYC  = `DPWSA_CYC(`DPWSA_RD_NS),
    parameter int BDD_CYC = `DPWSA_CYC(`DPWSA_BDD_NS)
) (
    input  wire logic                 mclk,
    input  wire logic                 arst_n,
    // User request side.
    input  wire logic                 req_valid,
    output logic                      req_ready,
    input  wire dpwsa_pkg::dpwsa_op_e req_op,
    input  wire logic [AW-1:0]        req_addr,
    input  wire logic [DW-1:0]        req_wdata,
    input  wire logic [1:0]           req_bytes,
    output logic                      rsp_valid,
    output logic [DW-1:0]             rsp_rdata,
    output logic                      rsp_granted,
    // Memory port pins.
    output logic [AW-1:0]             mem_addr,
    output logic                      chip_select_n,
    output logic                      read_write_n,
    output logic                      output_enable_n,
    output logic                      upper_byte_select_n,
    output logic                      lower_byte_select_n,
    output logic                      flag_space_select_n,
    output logic [DW-1:0]             dq_o,
    output logic                      dq_oe,
    input  wire logic [DW-1:0]        dq_i,
    input  wire logic                 busy_n
);

    localparam int TW = `DPWSA_TMR_W;

    // ------------------------------------------------------------------------
    // Cycle state and pin registers
    // ------------------------------------------------------------------------
    dpwsa_pkg::dpwsa_state_e state_r, state_nxt;
    dpwsa_pkg::dpwsa_op_e    op_r, op_nxt;
    logic [AW-1:0]           addr_r, addr_nxt;
    logic [DW-1:0]           wdata_r, wdata_nxt;
    logic [1:0]              bytes_r, bytes_nxt;
    logic                    rsp_valid_r, rsp_valid_nxt;
    logic [DW-1:0]           rdata_r, rdata_nxt;
    logic                    granted_r, granted_nxt;
    logic                    ce_n_r, ce_n_nxt;
    logic                    rw_n_r, rw_n_nxt;
    logic                    oe_n_r, oe_n_nxt;
    logic                    ub_n_r, ub_n_nxt;
    logic                    lb_n_r, lb_n_nxt;
    logic                    sem_n_r, sem_n_nxt;
    logic                    dq_oe_r, dq_oe_nxt;
    logic                    tmr_load;
    logic [TW-1:0]           tmr_val;
    logic                    tmr_done;
    logic                    is_sem;
    logic                    is_wr;
    logic                    active;

    dpwsa_timer #(
        .W        (TW)
    ) u_timer (
        .mclk     (mclk),
        .arst_n   (arst_n),
        .load     (tmr_load),
        .load_val (tmr_val),
        .done     (tmr_done)
    );

    assign is_sem = (op_nxt == dpwsa_pkg::DPWSA_SEM_RD) || (op_nxt == dpwsa_pkg::DPWSA_SEM_WR);
    assign is_wr  = (op_r == dpwsa_pkg::DPWSA_MEM_WR) || (op_r == dpwsa_pkg::DPWSA_SEM_WR);

    // ------------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------------
    // The address is only latched in idle, where every strobe is inactive,
    // so it never moves under an enabled cycle.
    always_comb begin
        state_nxt     = state_r;
        op_nxt        = op_r;
        addr_nxt      = addr_r;
        wdata_nxt     = wdata_r;
        bytes_nxt     = bytes_r;
        rsp_valid_nxt = 1'b0;
        rdata_nxt     = rdata_r;
        granted_nxt   = granted_r;
        tmr_load      = 1'b0;
        tmr_val       = '0;
        unique case (state_r)
            dpwsa_pkg::DPWSA_IDLE: begin
                if (req_valid) begin
                    op_nxt    = req_op;
                    addr_nxt  = req_addr; // R2
                    wdata_nxt = req_wdata;
                    bytes_nxt = req_bytes;
                    state_nxt = dpwsa_pkg::DPWSA_SETUP;
                end
            end
            dpwsa_pkg::DPWSA_SETUP: begin
                tmr_load = 1'b1;
                if (is_wr) begin
                    tmr_val   = TW'(WP_CYC - 1); // R4
                    state_nxt = dpwsa_pkg::DPWSA_STROBE;
                end else begin
                    tmr_val   = TW'(RD_CYC - 1);
                    state_nxt = dpwsa_pkg::DPWSA_READ;
                end
            end
            dpwsa_pkg::DPWSA_STROBE: begin
                // A held-off write was discarded, so the strobe is kept until
                // the hold lifts and then for the write hold time after it.
                if (!busy_n) begin
                    tmr_load = 1'b1;
                    tmr_val  = TW'(WH_CYC - 1); // R11 R12 R15
                end else if (tmr_done) begin
                    rsp_valid_nxt = 1'b1;
                    state_nxt     = dpwsa_pkg::DPWSA_IDLE;
                end
            end
            dpwsa_pkg::DPWSA_READ: begin
                if (!busy_n) begin
                    tmr_load = 1'b1;
                    tmr_val  = TW'(BDD_CYC - 1); // R13
                end else if (tmr_done) begin
                    rdata_nxt     = dq_i;
                    // A flag reads zero only on the port that owns it.
                    granted_nxt   = (op_r == dpwsa_pkg::DPWSA_SEM_RD) && !dq_i[`DPWSA_FLAG_BIT]; // R7 R18
                    rsp_valid_nxt = 1'b1;
                    state_nxt     = dpwsa_pkg::DPWSA_IDLE;
                end
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // Pin decode, taken from the next state so pins leave flip-flops
    // ------------------------------------------------------------------------
    always_comb begin
        active    = (state_nxt == dpwsa_pkg::DPWSA_STROBE) || (state_nxt == dpwsa_pkg::DPWSA_READ);
        ce_n_nxt  = !(active && !is_sem); // R5
        sem_n_nxt = !(active && is_sem); // R5
        ub_n_nxt  = !(active && !is_sem && bytes_nxt[1]);
        lb_n_nxt  = !(active && !is_sem && bytes_nxt[0]);
        rw_n_nxt  = (state_nxt != dpwsa_pkg::DPWSA_STROBE); // R1
        // Output enable stays high in writes, so the plain pulse width holds.
        oe_n_nxt  = (state_nxt != dpwsa_pkg::DPWSA_READ); // R4
        dq_oe_nxt = (state_nxt == dpwsa_pkg::DPWSA_STROBE); // R3
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_r     <= dpwsa_pkg::DPWSA_IDLE;
            op_r        <= dpwsa_pkg::DPWSA_MEM_RD;
            addr_r      <= '0;
            wdata_r     <= '0;
            bytes_r     <= 2'h0;
            rsp_valid_r <= 1'b0;
            rdata_r     <= '0;
            granted_r   <= 1'b0;
            ce_n_r      <= 1'b1;
            rw_n_r      <= 1'b1;
            oe_n_r      <= 1'b1;
            ub_n_r      <= 1'b1;
            lb_n_r      <= 1'b1;
            sem_n_r     <= 1'b1;
            dq_oe_r     <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            op_r        <= op_nxt;
            addr_r      <= addr_nxt;
            wdata_r     <= wdata_nxt;
            bytes_r     <= bytes_nxt;
            rsp_valid_r <= rsp_valid_nxt;
            rdata_r     <= rdata_nxt;
            granted_r   <= granted_nxt;
            ce_n_r      <= ce_n_nxt;
            rw_n_r      <= rw_n_nxt;
            oe_n_r      <= oe_n_nxt;
            ub_n_r      <= ub_n_nxt;
            lb_n_r      <= lb_n_nxt;
            sem_n_r     <= sem_n_nxt;
            dq_oe_r     <= dq_oe_nxt;
        end
    end

    assign req_ready           = (state_r == dpwsa_pkg::DPWSA_IDLE);
    assign rsp_valid           = rsp_valid_r;
    assign rsp_rdata           = rdata_r;
    assign rsp_granted         = granted_r;
    assign mem_addr            = addr_r;
    assign chip_select_n       = ce_n_r;
    assign read_write_n        = rw_n_r;
    assign output_enable_n     = oe_n_r;
    assign upper_byte_select_n = ub_n_r;
    assign lower_byte_select_n = lb_n_r;
    assign flag_space_select_n = sem_n_r;
    assign dq_o                = wdata_r;
    assign dq_oe               = dq_oe_r;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    property p_addr_quiet;
        @(posedge mclk) disable iff (!arst_n)
        $changed(mem_addr) |-> read_write_n && $past(read_write_n) && chip_select_n && flag_space_select_n;
    endproperty
    a_addr_quiet: assert property (p_addr_quiet) else $error("address moved under an active cycle"); // R2

    property p_no_drive_on_read;
        @(posedge mclk) disable iff (!arst_n)
        dq_oe |-> output_enable_n && !read_write_n;
    endproperty
    a_no_drive_on_read: assert property (p_no_drive_on_read) else $error("data driven outside a write"); // R3

    property p_write_width;
        @(posedge mclk) disable iff (!arst_n)
        $fell(read_write_n) |-> !read_write_n[*2];
    endproperty
    a_write_width: assert property (p_write_width) else $error("write pulse too short"); // R4

    property p_flag_select;
        @(posedge mclk) disable iff (!arst_n)
        !flag_space_select_n |-> chip_select_n && upper_byte_select_n && lower_byte_select_n;
    endproperty
    a_flag_select: assert property (p_flag_select) else $error("flag access with memory selected"); // R5

    property p_mem_select;
        @(posedge mclk) disable iff (!arst_n)
        !chip_select_n |-> flag_space_select_n && !(upper_byte_select_n && lower_byte_select_n);
    endproperty
    a_mem_select: assert property (p_mem_select) else $error("memory access without byte lane"); // R5

    property p_write_overlap;
        @(posedge mclk) disable iff (!arst_n)
        !read_write_n |-> (!chip_select_n || !flag_space_select_n) && dq_oe;
    endproperty
    a_write_overlap: assert property (p_write_overlap) else $error("write strobe without select"); // R1

    property p_hold_after_release;
        @(posedge mclk) disable iff (!arst_n)
        $rose(busy_n) && $past(!read_write_n) |-> !read_write_n;
    endproperty
    a_hold_after_release: assert property (p_hold_after_release) else $error("write dropped at release"); // R12

    property p_read_settle;
        @(posedge mclk) disable iff (!arst_n)
        $rose(busy_n) && !output_enable_n |-> !rsp_valid ##1 !rsp_valid;
    endproperty
    a_read_settle: assert property (p_read_settle) else $error("read taken before data settled"); // R13

    property p_grant;
        @(posedge mclk) disable iff (!arst_n)
        rsp_valid && op_r == dpwsa_pkg::DPWSA_SEM_RD |-> rsp_granted == !rsp_rdata[`DPWSA_FLAG_BIT];
    endproperty
    a_grant: assert property (p_grant) else $error("grant does not match flag value"); // R18

    property p_blocked_write;
        @(posedge mclk) disable iff (!arst_n)
        !busy_n && !read_write_n |=> !read_write_n;
    endproperty
    a_blocked_write: assert property (p_blocked_write) else $error("held write ended early"); // R15

    c_mem_wr: cover property (@(posedge mclk) disable iff (!arst_n) rsp_valid && op_r == dpwsa_pkg::DPWSA_MEM_WR);
    c_mem_rd: cover property (@(posedge mclk) disable iff (!arst_n) rsp_valid && op_r == dpwsa_pkg::DPWSA_MEM_RD);
    c_sem_grant: cover property (@(posedge mclk) disable iff (!arst_n) rsp_valid && rsp_granted);
    c_busy_wr: cover property (@(posedge mclk) disable iff (!arst_n) !busy_n && !read_write_n ##1 busy_n);

endmodule

// ==== rtl/dpwsa_pkg.sv ====
package dpwsa_pkg;

    typedef enum logic [1:0] {
        DPWSA_MEM_RD = 2'h0,
        DPWSA_MEM_WR = 2'h1,
        DPWSA_SEM_RD = 2'h2,
        DPWSA_SEM_WR = 2'h3
    } dpwsa_op_e;

    typedef enum logic [1:0] {
        DPWSA_IDLE    = 2'h0,
        DPWSA_SETUP   = 2'h1,
        DPWSA_STROBE  = 2'h2,
        DPWSA_READ    = 2'h3
    } dpwsa_state_e;

endpackage

// ==== rtl/dpwsa_timer.sv ====
`include "dpwsa_cfg.svh"

module dpwsa_timer #(
    parameter int W = `DPWSA_TMR_W
) (
    input  wire logic         mclk,
    input  wire logic         arst_n,
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    output logic              done
);

    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;

    always_comb begin
        if (load) begin
            cnt_nxt = load_val;
        end else if (cnt_r != '0) begin
            cnt_nxt = cnt_r - W'(1);
        end else begin
            cnt_nxt = cnt_r;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign done = (cnt_r == '0);

endmodule

// ==== tb/dpwsa_dev_model.sv ====
// ----------------------------------------------------------------------------
// Behavioural dual-port device in master mode, seen from one port
// ----------------------------------------------------------------------------
module dpwsa_dev_model #(
    parameter int RD_DLY = 30
) (
    input  wire logic [11:0] mem_addr,
    input  wire logic        chip_select_n,
    input  wire logic        read_write_n,
    input  wire logic        output_enable_n,
    input  wire logic        upper_byte_select_n,
    input  wire logic        lower_byte_select_n,
    input  wire logic        flag_space_select_n,
    input  wire logic [15:0] host_dq,
    input  wire logic        host_dq_oe,
    output logic [15:0]      dev_dq,
    output logic             busy_n,
    input  wire logic        peer_cs_n,
    input  wire logic [11:0] peer_addr,
    input  wire logic        peer_flag_req,
    output logic [7:0]       viol
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [15:0] mem [4096];
    logic [1:0]  own [8];
    logic        lanes;
    logic        mem_wr;
    logic        flag_wr;
    logic        drv;
    logic        flag_rd;
    logic        peer_first;
    logic        w_up;
    logic        w_lo;
    logic        w_held;
    logic [15:0] w_dat;
    logic [11:0] w_a;
    logic [15:0] rd_val;
    logic [15:0] last;

    initial begin
        viol = 8'h00;
        peer_first = 1'b0;
        last = 16'h0000;
        foreach (own[i]) own[i] = 2'h0;
    end

    assign lanes   = !upper_byte_select_n || !lower_byte_select_n;
    assign mem_wr  = !chip_select_n && lanes && flag_space_select_n && !read_write_n;
    assign flag_wr = (chip_select_n || !lanes) && !flag_space_select_n && !read_write_n;
    assign flag_rd = (chip_select_n || !lanes) && !flag_space_select_n && read_write_n;
    assign drv     = !output_enable_n && read_write_n && (flag_rd || (!chip_select_n && lanes));

    // The peer only wins when it had the word selected before this port's select fell.
    always @(negedge chip_select_n) peer_first = !peer_cs_n && peer_addr == mem_addr;
    assign busy_n = !(peer_first && !peer_cs_n && !chip_select_n && peer_addr == mem_addr);

    // Capture while the write is open, because the selects rise together at its end.
    always @(*) begin
        if (mem_wr || flag_wr) begin
            w_up = !upper_byte_select_n;
            w_lo = !lower_byte_select_n;
            w_dat = host_dq;
            w_a = mem_addr;
            w_held = peer_first && !peer_cs_n && peer_addr == mem_addr;
        end
    end
    always @(negedge mem_wr) begin
        if (!w_held && w_up) mem[w_a][15:8] = w_dat[15:8];
        if (!w_held && w_lo) mem[w_a][7:0] = w_dat[7:0];
    end
    always @(negedge flag_wr) begin
        if (!w_dat[0] && own[w_a[2:0]] == 2'h0) own[w_a[2:0]] = 2'h1;
        else if (w_dat[0] && own[w_a[2:0]] == 2'h1) own[w_a[2:0]] = 2'h0;
    end
    always @(posedge peer_flag_req) if (own[0] == 2'h0) own[0] = 2'h2;
    always @(negedge peer_flag_req) if (own[0] == 2'h2) own[0] = 2'h0;

    assign rd_val = flag_rd ? {16{own[mem_addr[2:0]] != 2'h1}} : mem[mem_addr];
    always @(*) if (drv) last = rd_val;
    // Released lines show the inverse of the last value so stale data never passes.
    assign #(RD_DLY) dev_dq = drv ? rd_val : ~last;

    always @(posedge (host_dq_oe && drv)) viol = viol + 8'h01;
    always @(mem_addr) if (mem_wr) viol = viol + 8'h01;
endmodule

// ==== tb/test_dual_port_write_semaphore_arbiter.sv ====
module test_dual_port_write_semaphore_arbiter;
    timeunit 1ns;
    timeprecision 100ps;

    logic                 mclk;
    logic                 arst_n;
    logic                 req_valid;
    logic                 req_ready;
    dpwsa_pkg::dpwsa_op_e req_op;
    logic [11:0]          req_addr;
    logic [15:0]          req_wdata;
    logic [1:0]           req_bytes;
    logic                 rsp_valid;
    logic [15:0]          rsp_rdata;
    logic                 rsp_granted;
    logic [11:0]          mem_addr;
    logic                 chip_select_n;
    logic                 read_write_n;
    logic                 output_enable_n;
    logic                 upper_byte_select_n;
    logic                 lower_byte_select_n;
    logic                 flag_space_select_n;
    logic [15:0]          dq_o;
    logic                 dq_oe;
    logic [15:0]          dq_i;
    logic                 busy_n;
    logic                 peer_cs_n;
    logic [11:0]          peer_addr;
    logic                 peer_flag_req;
    logic [7:0]           viol;
    int                   num_errors;
    int                   cmp_count;
    int                   strb;
    int                   held;
    int                   held_wr;
    int                   oe_wr;

    dpwsa_host i_dpwsa_host (.mclk(mclk), .arst_n(arst_n), .req_valid(req_valid), .req_ready(req_ready),
        .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata), .req_bytes(req_bytes),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_granted(rsp_granted), .mem_addr(mem_addr),
        .chip_select_n(chip_select_n), .read_write_n(read_write_n), .output_enable_n(output_enable_n),
        .upper_byte_select_n(upper_byte_select_n), .lower_byte_select_n(lower_byte_select_n),
        .flag_space_select_n(flag_space_select_n), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i), .busy_n(busy_n));

    dpwsa_dev_model i_dpwsa_dev_model (.mem_addr(mem_addr), .chip_select_n(chip_select_n),
        .read_write_n(read_write_n), .output_enable_n(output_enable_n),
        .upper_byte_select_n(upper_byte_select_n), .lower_byte_select_n(lower_byte_select_n),
        .flag_space_select_n(flag_space_select_n), .host_dq(dq_o), .host_dq_oe(dq_oe), .dev_dq(dq_i),
        .busy_n(busy_n), .peer_cs_n(peer_cs_n), .peer_addr(peer_addr), .peer_flag_req(peer_flag_req),
        .viol(viol));

    always #20 mclk = ~mclk;

    // ------------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------------
    task automatic finish_test();
        $display("mismatches=%0d compares=%0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Entered just after an edge; the counters describe the pins during the transfer.
    task automatic do_op(input dpwsa_pkg::dpwsa_op_e op, input logic [11:0] a, input logic [15:0] d,
                         input logic [1:0] b);
        int n;
        n = 0;
        strb = 0;
        held = 0;
        held_wr = 0;
        oe_wr = 0;
        chk({15'h0000, req_ready}, 16'h0001);
        req_op = op;
        req_addr = a;
        req_wdata = d;
        req_bytes = b;
        req_valid = 1'b1;
        @(posedge mclk);
        #1;
        req_valid = 1'b0;
        while (rsp_valid !== 1'b1 && n < 60) begin
            strb += int'(!chip_select_n || !flag_space_select_n);
            held += int'(!busy_n);
            held_wr += int'(!busy_n && !read_write_n);
            oe_wr += int'(!output_enable_n && !read_write_n);
            @(posedge mclk);
            #1;
            n++;
        end
        if (rsp_valid !== 1'b1) begin
            num_errors++;
            finish_test();
        end
    endtask

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic t_reset();
        chk({10'h000, chip_select_n, read_write_n, output_enable_n, upper_byte_select_n,
             lower_byte_select_n, flag_space_select_n}, 16'h003f);
        chk({13'h0000, dq_oe, rsp_valid, req_ready}, 16'h0001);
        chk({4'h0, mem_addr}, 16'h0000);
    endtask

    task automatic t_mem();
        do_op(dpwsa_pkg::DPWSA_MEM_WR, 12'h005, 16'h1234, 2'h3);
        chk(16'(strb), 16'h0002);
        chk(16'(oe_wr), 16'h0000);
        do_op(dpwsa_pkg::DPWSA_MEM_WR, 12'h005, 16'hab00, 2'h2);
        do_op(dpwsa_pkg::DPWSA_MEM_WR, 12'h005, 16'hffcd, 2'h1);
        do_op(dpwsa_pkg::DPWSA_MEM_WR, 12'hfff, 16'h5a5a, 2'h3);
        do_op(dpwsa_pkg::DPWSA_MEM_RD, 12'h005, 16'h0000, 2'h3);
        chk(rsp_rdata, 16'habcd);
        do_op(dpwsa_pkg::DPWSA_MEM_RD, 12'hfff, 16'h0000, 2'h3);
        chk(rsp_rdata, 16'h5a5a);
    endtask

    task automatic t_flags();
        for (int f = 1; f < 4; f++) begin
            do_op(dpwsa_pkg::DPWSA_SEM_RD, 12'(f), 16'h0000, 2'h0);
            chk(rsp_rdata, 16'hffff);
            do_op(dpwsa_pkg::DPWSA_SEM_WR, 12'(f), 16'hfffe, 2'h0);
            do_op(dpwsa_pkg::DPWSA_SEM_RD, 12'(f), 16'h0000, 2'h0);
            chk(rsp_rdata, 16'h0000);
            chk({15'h0000, rsp_granted}, 16'h0001);
            do_op(dpwsa_pkg::DPWSA_SEM_WR, 12'(f), 16'hffff, 2'h0);
            do_op(dpwsa_pkg::DPWSA_SEM_RD, 12'(f), 16'h0000, 2'h0);
            chk(rsp_rdata, 16'hffff);
        end
        peer_flag_req = 1'b1;
        do_op(dpwsa_pkg::DPWSA_SEM_WR, 12'h000, 16'hfffe, 2'h0);
        do_op(dpwsa_pkg::DPWSA_SEM_RD, 12'h000, 16'h0000, 2'h0);
        chk({rsp_rdata[15:1], rsp_granted}, 16'hfffe);
        peer_flag_req = 1'b0;
        do_op(dpwsa_pkg::DPWSA_SEM_WR, 12'h000, 16'hfffe, 2'h0);
        do_op(dpwsa_pkg::DPWSA_SEM_RD, 12'h000, 16'h0000, 2'h0);
        chk({rsp_rdata[15:1], rsp_granted}, 16'h0001);
    endtask

    // The peer holds word 7 first, so this port is stalled until the peer lets go.
    task automatic t_busy(input dpwsa_pkg::dpwsa_op_e op);
        peer_addr = 12'h007;
        peer_cs_n = 1'b0;
        fork
            do_op(op, 12'h007, 16'hc3a5, 2'h3);
            begin
                // Released on the edge so the pin counters never race the release.
                repeat (6) @(posedge mclk);
                peer_cs_n <= 1'b1;
            end
        join
        chk(16'(held > 0), 16'h0001);
    endtask

    initial begin
        mclk = 1'b0;
        arst_n = 1'b0;
        req_valid = 1'b0;
        req_op = dpwsa_pkg::DPWSA_MEM_RD;
        req_addr = 12'h000;
        req_wdata = 16'h0000;
        req_bytes = 2'h3;
        peer_cs_n = 1'b1;
        peer_addr = 12'h000;
        peer_flag_req = 1'b0;
        num_errors = 0;
        cmp_count = 0;
        repeat (4) @(posedge mclk);
        #1;
        t_reset();
        arst_n = 1'b1;
        t_mem();
        t_flags();
        t_busy(dpwsa_pkg::DPWSA_MEM_WR);
        chk(16'(held_wr == held), 16'h0001);
        chk(16'(strb > held), 16'h0001);
        t_busy(dpwsa_pkg::DPWSA_MEM_RD);
        chk(rsp_rdata, 16'hc3a5);
        chk({8'h00, viol}, 16'h0000);
        finish_test();
    end
endmodule
